// ==== verilog/timer_pkg.sv ====
package timer_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0]      OFF_CONTROL_TWO  = 8'h00;
	localparam logic [7:0]      OFF_CONTROL_ONE  = 8'h04;
	localparam logic [7:0]      OFF_STATUS       = 8'h08;
	localparam logic [1:0][7:0] OFF_CAPTURE_HIGH = {8'h1C, 8'h0C};
	localparam logic [1:0][7:0] OFF_CAPTURE_LOW  = {8'h20, 8'h10};
	localparam logic [1:0][7:0] OFF_COMPARE_HIGH = {8'h24, 8'h14};
	localparam logic [1:0][7:0] OFF_COMPARE_LOW  = {8'h28, 8'h18};
	localparam logic [7:0]      OFF_COUNT_HIGH   = 8'h2C;
	localparam logic [7:0]      OFF_COUNT_LOW    = 8'h30;
	localparam logic [7:0]      OFF_ALT_HIGH     = 8'h34;
	localparam logic [7:0]      OFF_ALT_LOW      = 8'h38;

	// ****************************************
	// Control two fields
	// ****************************************
	localparam int CTL2_EDGE     = 0;
	localparam int CTL2_CLK      = 1;
	localparam int CTL2_CAP_EDGE = 3;
	localparam int CTL2_PWM      = 4;
	localparam int CTL2_OPM      = 5;
	localparam int CTL2_OE_TWO   = 6;
	localparam int CTL2_OE_ONE   = 7;

	// ****************************************
	// Control one fields
	// ****************************************
	localparam int         CTL1_LEVEL_ONE = 0;
	localparam int         CTL1_CAP_EDGE  = 1;
	localparam int         CTL1_LEVEL_TWO = 2;
	localparam int         CTL1_FORCE     = 3;
	localparam int         CTL1_CMP_IE    = 6;
	localparam int         CTL1_CAP_IE    = 7;
	localparam logic [7:0] CTL1_STORE     = 8'hC7;

	// ****************************************
	// Status fields
	// ****************************************
	localparam logic [1:0][2:0] ST_CAPTURE = {3'h4, 3'h7};
	localparam logic [1:0][2:0] ST_COMPARE = {3'h3, 3'h6};

	// ****************************************
	// Clock select codes
	// ****************************************
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV2 = 2'h2;
	localparam logic [1:0] CLK_EXT  = 2'h3;

	// ****************************************
	// Reset and reload values
	// ****************************************
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [15:0] COMPARE_RESET  = 16'h8000;
	localparam logic [15:0] COUNTER_RELOAD = 16'hFFFC;
	localparam logic [15:0] CAPTURE_PULSE  = 16'hFFFD;

	// ****************************************
	// Bus responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verilog/timer_capture_compare_pulse.sv ====
`timescale 1ns/1ns
`default_nettype none

module timer_capture_compare_pulse #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Timer pins
	input  wire logic              ext_clock_pin,
	input  wire logic              capture_pin_one,
	input  wire logic              capture_pin_two,
	output logic                   compare_pin_one,
	output logic                   compare_pin_one_oe,
	output logic                   compare_pin_two,
	output logic                   compare_pin_two_oe,
	// Interrupt request
	output logic                   timer_irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]       ctl_one;
		logic [7:0]       ctl_two;
		logic [15:0]      count;
		logic [2:0]       presc;
		logic             tick_d;
		logic [2:0]       ext_sync;
		logic [1:0]       cap_s1;
		logic [1:0]       cap_s2;
		logic [1:0]       cap_s3;
		logic [1:0][15:0] capture_value;
		logic [1:0][15:0] compare_value;
		logic [1:0]       compare_hold;
		logic [1:0]       capture_lock;
		logic [1:0]       capture_flag;
		logic [1:0]       compare_flag;
		logic [1:0]       capture_seen;
		logic [1:0]       compare_seen;
		logic [1:0]       pin;
		logic [1:0]       pin_oe;
		logic             irq;
		logic             aw_rdy;
		logic             w_rdy;
		logic             ar_rdy;
		logic [ADDR_W-1:0] wr_addr;
		logic [7:0]       wr_data;
		logic             wr_lane;
		logic             b_vld;
		logic [1:0]       b_resp;
		logic             r_vld;
		logic [1:0]       r_resp;
		logic [7:0]       r_data;
	} state_s;

	state_s s;
	state_s next_s;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		at = ((a >> 2) == (ADDR_W'(off) >> 2));
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic             tick;
		logic             pwm;
		logic             one_pulse_select;
		logic [1:0]       cap_edge;
		logic [1:0]       oe;
		logic [1:0]       level;
		logic [1:0]       match;
		logic [15:0]      target;
		logic             do_wr;
		logic             do_rd;
		logic             wr_hit;
		logic             rd_hit;
		logic [7:0]       rd_val;
		logic             count_reload;
		next_s       = s;
		tick         = 1'b0;
		match        = 2'h0;
		target       = 16'h0;
		wr_hit       = 1'b0;
		rd_hit       = 1'b0;
		rd_val       = 8'h00;
		count_reload = 1'b0;
		cap_edge     = 2'h0;
		do_wr        = 1'b0;
		do_rd        = 1'b0;
		pwm          = s.ctl_two[timer_pkg::CTL2_PWM];
		one_pulse_select          = s.ctl_two[timer_pkg::CTL2_OPM] & ~pwm;
		oe           = {s.ctl_two[timer_pkg::CTL2_OE_TWO], s.ctl_two[timer_pkg::CTL2_OE_ONE]};
		level        = {s.ctl_one[timer_pkg::CTL1_LEVEL_TWO], s.ctl_one[timer_pkg::CTL1_LEVEL_ONE]};

		// Synchronisers
		next_s.ext_sync = {s.ext_sync[1:0], ext_clock_pin};
		next_s.cap_s1   = {capture_pin_two, capture_pin_one};
		next_s.cap_s2   = s.cap_s1;
		next_s.cap_s3   = s.cap_s2;

		// Timer clock
		next_s.presc = s.presc + 3'h1;
		case (s.ctl_two[timer_pkg::CTL2_CLK +: 2])
			timer_pkg::CLK_DIV2: tick = s.presc[0];
			timer_pkg::CLK_DIV4: tick = &s.presc[1:0];
			timer_pkg::CLK_DIV8: tick = &s.presc;
			timer_pkg::CLK_EXT:  tick = (s.ext_sync[1] != s.ext_sync[2]) &&
				(s.ext_sync[1] == s.ctl_two[timer_pkg::CTL2_EDGE]);
			default:             tick = 1'b0;
		endcase
		next_s.tick_d = tick;
		if (tick) begin
			next_s.count = s.count + 16'h1;
		end

		// Capture edges, polarity per channel
		cap_edge[0] = (s.cap_s2[0] != s.cap_s3[0]) &&
			(s.cap_s2[0] == s.ctl_one[timer_pkg::CTL1_CAP_EDGE]);
		cap_edge[1] = (s.cap_s2[1] != s.cap_s3[1]) &&
			(s.cap_s2[1] == s.ctl_two[timer_pkg::CTL2_CAP_EDGE]);

		// Compare matches, one count late except divide by two
		for (int i = 0; i < 2; i++) begin
			if (s.ctl_two[timer_pkg::CTL2_CLK +: 2] == timer_pkg::CLK_DIV2) begin
				target = s.compare_value[i];
			end else begin
				target = s.compare_value[i] + 16'h1;
			end
			match[i] = s.tick_d && !s.compare_hold[i] && (s.count == target);
		end

		// Bus write path
		do_wr = !s.aw_rdy && !s.w_rdy && !s.b_vld;
		if (do_wr) begin
			next_s.b_vld = 1'b1;
			wr_hit       = at(s.wr_addr, timer_pkg::OFF_CONTROL_TWO) ||
				at(s.wr_addr, timer_pkg::OFF_CONTROL_ONE) || at(s.wr_addr, timer_pkg::OFF_STATUS) ||
				at(s.wr_addr, timer_pkg::OFF_COUNT_HIGH) || at(s.wr_addr, timer_pkg::OFF_COUNT_LOW) ||
				at(s.wr_addr, timer_pkg::OFF_ALT_HIGH) || at(s.wr_addr, timer_pkg::OFF_ALT_LOW);
			if (s.wr_lane && at(s.wr_addr, timer_pkg::OFF_CONTROL_TWO)) begin
				next_s.ctl_two = s.wr_data;
			end
			if (s.wr_lane && at(s.wr_addr, timer_pkg::OFF_CONTROL_ONE)) begin
				next_s.ctl_one = s.wr_data & timer_pkg::CTL1_STORE;
				for (int i = 0; i < 2; i++) begin
					if (s.wr_data[timer_pkg::CTL1_FORCE + i] && !pwm &&
						!s.ctl_two[timer_pkg::CTL2_OPM]) begin
						next_s.pin[i] = s.wr_data[2 * i];
					end
				end
			end
			if (s.wr_lane && (at(s.wr_addr, timer_pkg::OFF_COUNT_LOW) ||
				at(s.wr_addr, timer_pkg::OFF_ALT_LOW))) begin
				count_reload = 1'b1;
			end
			for (int i = 0; i < 2; i++) begin
				if (at(s.wr_addr, timer_pkg::OFF_CAPTURE_HIGH[i])) begin
					wr_hit = 1'b1;
				end
				if (at(s.wr_addr, timer_pkg::OFF_CAPTURE_LOW[i])) begin
					wr_hit = 1'b1;
					if (s.capture_seen[i]) begin
						next_s.capture_flag[i] = 1'b0;
						next_s.capture_seen[i] = 1'b0;
					end
				end
				if (at(s.wr_addr, timer_pkg::OFF_COMPARE_HIGH[i])) begin
					wr_hit = 1'b1;
					if (s.wr_lane) begin
						next_s.compare_value[i][15:8] = s.wr_data;
						next_s.compare_hold[i]        = 1'b1;
					end
				end
				if (at(s.wr_addr, timer_pkg::OFF_COMPARE_LOW[i])) begin
					wr_hit = 1'b1;
					if (s.wr_lane) begin
						next_s.compare_value[i][7:0] = s.wr_data;
						next_s.compare_hold[i]       = 1'b0;
					end
					if (s.compare_seen[i]) begin
						next_s.compare_flag[i] = 1'b0;
						next_s.compare_seen[i] = 1'b0;
					end
				end
			end
			next_s.b_resp = wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
		end

		// Bus read path
		do_rd = s.ar_rdy && arvalid;
		if (do_rd) begin
			next_s.ar_rdy = 1'b0;
			next_s.r_vld  = 1'b1;
			rd_hit        = 1'b1;
			if (at(araddr, timer_pkg::OFF_CONTROL_TWO)) begin
				rd_val = s.ctl_two;
			end else if (at(araddr, timer_pkg::OFF_CONTROL_ONE)) begin
				rd_val = s.ctl_one;
			end else if (at(araddr, timer_pkg::OFF_STATUS)) begin
				for (int i = 0; i < 2; i++) begin
					rd_val[timer_pkg::ST_CAPTURE[i]] = s.capture_flag[i];
					rd_val[timer_pkg::ST_COMPARE[i]] = s.compare_flag[i];
				end
				next_s.capture_seen = s.capture_seen | s.capture_flag;
				next_s.compare_seen = s.compare_seen | s.compare_flag;
			end else if (at(araddr, timer_pkg::OFF_COUNT_HIGH) ||
				at(araddr, timer_pkg::OFF_ALT_HIGH)) begin
				rd_val = s.count[15:8];
			end else if (at(araddr, timer_pkg::OFF_COUNT_LOW) ||
				at(araddr, timer_pkg::OFF_ALT_LOW)) begin
				rd_val = s.count[7:0];
			end else begin
				rd_hit = 1'b0;
			end
			for (int i = 0; i < 2; i++) begin
				if (at(araddr, timer_pkg::OFF_CAPTURE_HIGH[i])) begin
					rd_hit                 = 1'b1;
					rd_val                 = s.capture_value[i][15:8];
					next_s.capture_lock[i] = 1'b1;
				end
				if (at(araddr, timer_pkg::OFF_CAPTURE_LOW[i])) begin
					rd_hit                 = 1'b1;
					rd_val                 = s.capture_value[i][7:0];
					next_s.capture_lock[i] = 1'b0;
					if (s.capture_seen[i]) begin
						next_s.capture_flag[i] = 1'b0;
						next_s.capture_seen[i] = 1'b0;
					end
				end
				if (at(araddr, timer_pkg::OFF_COMPARE_HIGH[i])) begin
					rd_hit = 1'b1;
					rd_val = s.compare_value[i][15:8];
				end
				if (at(araddr, timer_pkg::OFF_COMPARE_LOW[i])) begin
					rd_hit = 1'b1;
					rd_val = s.compare_value[i][7:0];
					if (s.compare_seen[i]) begin
						next_s.compare_flag[i] = 1'b0;
						next_s.compare_seen[i] = 1'b0;
					end
				end
			end
			next_s.r_data = rd_val;
			next_s.r_resp = rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
		end

		// Capture channel two, usable in every mode
		if (cap_edge[1] && !s.capture_lock[1]) begin
			next_s.capture_flag[1]  = 1'b1;
			next_s.capture_value[1] = s.count;
		end

		// Channel one by mode
		if (pwm) begin
			if (match[0]) begin
				next_s.pin[0] = level[0];
			end
			if (match[1]) begin
				next_s.pin[0]          = level[1];
				next_s.capture_flag[0] = 1'b1;
				count_reload           = 1'b1;
			end
		end else if (one_pulse_select) begin
			if (cap_edge[0]) begin
				count_reload  = 1'b1;
				next_s.pin[0] = level[1];
				if (!s.capture_lock[0]) begin
					next_s.capture_flag[0]  = 1'b1;
					next_s.capture_value[0] = timer_pkg::CAPTURE_PULSE;
				end
			end
			if (match[0]) begin
				next_s.pin[0] = level[0];
			end
			if (match[1]) begin
				next_s.compare_flag[1] = 1'b1;
			end
		end else begin
			if (cap_edge[0] && !s.capture_lock[0]) begin
				next_s.capture_flag[0]  = 1'b1;
				next_s.capture_value[0] = s.count;
			end
			for (int i = 0; i < 2; i++) begin
				if (match[i]) begin
					next_s.compare_flag[i] = 1'b1;
					if (oe[i]) begin
						next_s.pin[i] = level[i];
					end
				end
			end
		end
		if (count_reload) begin
			next_s.count  = timer_pkg::COUNTER_RELOAD;
			next_s.presc  = 3'h0;
			next_s.tick_d = 1'b0;
		end

		// Shared interrupt request
		next_s.irq = |(next_s.capture_flag & {2{s.ctl_one[timer_pkg::CTL1_CAP_IE]}}) |
			|(next_s.compare_flag & {2{s.ctl_one[timer_pkg::CTL1_CMP_IE]}});

		// Pin output enables, registered with the control they decode
		next_s.pin_oe[0] = next_s.ctl_two[timer_pkg::CTL2_OE_ONE] |
			next_s.ctl_two[timer_pkg::CTL2_PWM];
		next_s.pin_oe[1] = next_s.ctl_two[timer_pkg::CTL2_OE_TWO] &
			~next_s.ctl_two[timer_pkg::CTL2_PWM] & ~next_s.ctl_two[timer_pkg::CTL2_OPM];

		// Bus handshakes
		if (s.aw_rdy && awvalid) begin
			next_s.aw_rdy  = 1'b0;
			next_s.wr_addr = awaddr;
		end
		if (s.w_rdy && wvalid) begin
			next_s.w_rdy   = 1'b0;
			next_s.wr_data = wdata[7:0];
			next_s.wr_lane = wstrb[0];
		end
		if (s.b_vld && bready) begin
			next_s.b_vld  = 1'b0;
			next_s.aw_rdy = 1'b1;
			next_s.w_rdy  = 1'b1;
		end
		if (s.r_vld && rready) begin
			next_s.r_vld  = 1'b0;
			next_s.ar_rdy = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s               <= '0;
			s.ctl_one       <= timer_pkg::CONTROL_RESET;
			s.ctl_two       <= timer_pkg::CONTROL_RESET;
			s.count         <= timer_pkg::COUNTER_RELOAD;
			s.compare_value <= {2{timer_pkg::COMPARE_RESET}};
			s.pin           <= 2'h0;
			s.aw_rdy        <= 1'b1;
			s.w_rdy         <= 1'b1;
			s.ar_rdy        <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign awready            = s.aw_rdy;
	assign wready             = s.w_rdy;
	assign bvalid             = s.b_vld;
	assign bresp              = s.b_resp;
	assign arready            = s.ar_rdy;
	assign rvalid             = s.r_vld;
	assign rresp              = s.r_resp;
	assign rdata              = {24'h000000, s.r_data};
	assign compare_pin_one    = s.pin[0];
	assign compare_pin_two    = s.pin[1];
	assign compare_pin_one_oe = s.pin_oe[0];
	assign compare_pin_two_oe = s.pin_oe[1];
	assign timer_irq          = s.irq;

endmodule // timer_capture_compare_pulse

`default_nettype wire

// ==== dv/timer_pin_sources.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// External pin sources
// ****************************************
module timer_pin_sources (
	// Clock
	input  wire logic aclk,
	// Commands from bench
	input  wire logic ext_req,
	input  wire logic cap_one_lvl,
	input  wire logic cap_two_lvl,
	// Pins
	output logic      ext_clock_pin,
	output logic      capture_pin_one,
	output logic      capture_pin_two
);
	logic [3:0] cnt = 4'h0;

	// One external clock cycle, four high then four low
	always @(posedge aclk) begin
		capture_pin_one <= cap_one_lvl;
		capture_pin_two <= cap_two_lvl;
		if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (ext_req)
			cnt <= 4'h8;
	end

	// Stands low between requested cycles
	assign ext_clock_pin = (cnt > 4'h4);
endmodule // timer_pin_sources

`default_nettype wire

// ==== dv/timer_ccp_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Port checker
// ****************************************
module timer_ccp_asserts #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Bus
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic [31:0]       wdata,
	input wire logic [3:0]        wstrb,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic              rvalid,
	input wire logic              rready,
	// Pins
	input wire logic              compare_pin_one,
	input wire logic              compare_pin_one_oe,
	input wire logic              compare_pin_two,
	input wire logic              compare_pin_two_oe,
	input wire logic              timer_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [7:0] ctl;
	logic       wr_go;

	// Shadow of control two
	assign wr_go = awvalid && awready && wvalid && wready;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctl <= 8'h00;
		else if (wr_go && awaddr == timer_pkg::OFF_CONTROL_TWO && wstrb[0])
			ctl <= wdata[7:0];
	end

	AST_RESET_PINS: assert property ($rose(aresetn) |->
		!compare_pin_one && !compare_pin_two && !timer_irq && !compare_pin_one_oe)
		else $error("pins not low after reset");
	AST_OE_ONE: assert property (bvalid |->
		compare_pin_one_oe == (ctl[timer_pkg::CTL2_OE_ONE] || ctl[timer_pkg::CTL2_PWM]))
		else $error("output enable one wrong");
	AST_OE_TWO: assert property (bvalid |-> compare_pin_two_oe ==
		(ctl[timer_pkg::CTL2_OE_TWO] && !ctl[timer_pkg::CTL2_PWM] && !ctl[timer_pkg::CTL2_OPM]))
		else $error("output enable two wrong");
	AST_B_TIME: assert property (wr_go |-> ##[1:2] bvalid)
		else $error("write response late");
	AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write response not retired");
	AST_R_TIME: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read data not retired");
	AST_AW_LOCK: assert property (!awready && !(bvalid && bready) |=> !awready)
		else $error("second write accepted");

	cover property (compare_pin_one_oe && $rose(compare_pin_one));
	cover property ($rose(timer_irq));
	cover property (bvalid && bresp == timer_pkg::RESP_SLVERR);
endmodule // timer_ccp_asserts

bind timer_capture_compare_pulse timer_ccp_asserts #(.ADDR_W(ADDR_W)) timer_ccp_asserts_inst (
	.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .compare_pin_one,
	.compare_pin_one_oe, .compare_pin_two, .compare_pin_two_oe, .timer_irq);

`default_nettype wire

// ==== dv/timer_capture_compare_pulse_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module timer_capture_compare_pulse_bench;
	// ****************************************
	// Signals
	// ****************************************
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, timer_irq;
	logic        ext_clock_pin, capture_pin_one, capture_pin_two;
	logic        compare_pin_one, compare_pin_one_oe, compare_pin_two, compare_pin_two_oe;
	logic        ext_req, cap_one_lvl, cap_two_lvl;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	int          err_count, checked;

	timer_capture_compare_pulse timer_capture_compare_pulse_inst (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.ext_clock_pin, .capture_pin_one, .capture_pin_two, .compare_pin_one,
		.compare_pin_one_oe, .compare_pin_two, .compare_pin_two_oe, .timer_irq);

	timer_pin_sources timer_pin_sources_inst (.aclk, .ext_req, .cap_one_lvl, .cap_two_lvl,
		.ext_clock_pin, .capture_pin_one, .capture_pin_two);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_pin(input logic lv);
		for (int i = 0; i < 300 && compare_pin_one !== lv; i++) @(posedge aclk);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		idle(30000);
		err_count++;
		end_of_test();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{ext_req, cap_one_lvl, cap_two_lvl} = 3'h0;
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h00000000, 4'hF};
		err_count = 0;
		checked = 0;
		idle(8);
		aresetn <= 1'b1;
		chk("pin one reset", compare_pin_one, 1'b0);
		rd(timer_pkg::OFF_COMPARE_HIGH[0]);
		chk("cmp1 hi reset", d, 8'h80);
		rd(timer_pkg::OFF_COMPARE_LOW[0]);
		chk("cmp1 lo reset", d, 8'h00);
		rd(timer_pkg::OFF_COMPARE_HIGH[1]);
		chk("cmp2 hi reset", d, 8'h80);
		wr(timer_pkg::OFF_COMPARE_HIGH[1], 8'h12);
		wr(timer_pkg::OFF_COMPARE_LOW[1], 8'h34);
		rd(timer_pkg::OFF_COMPARE_HIGH[1]);
		chk("cmp2 hi", d, 8'h12);
		rd(timer_pkg::OFF_COMPARE_LOW[1]);
		chk("cmp2 lo", d, 8'h34);
		rd(8'h3C);
		chk("unmapped read", rs, timer_pkg::RESP_SLVERR);
		wr(8'h3C, 8'h00);
		chk("unmapped write", rs, timer_pkg::RESP_SLVERR);
		// Compare one with pin, interrupt and clear
		wr(timer_pkg::OFF_CONTROL_TWO, 8'h84);
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h41);
		wr(timer_pkg::OFF_COMPARE_HIGH[0], 8'h00);
		wr(timer_pkg::OFF_COMPARE_LOW[0], 8'h10);
		wr(timer_pkg::OFF_COUNT_LOW, 8'h00);
		wait_pin(1'b1);
		chk("pin one match", compare_pin_one, 1'b1);
		idle(2);
		chk("irq compare", timer_irq, 1'b1);
		rd(timer_pkg::OFF_STATUS);
		chk("cmp1 flag", d[6], 1'b1);
		wr(timer_pkg::OFF_COMPARE_LOW[0], 8'h10);
		rd(timer_pkg::OFF_STATUS);
		chk("cmp1 flag cleared", d[6], 1'b0);
		chk("irq cleared", timer_irq, 1'b0);
		// Half written compare value
		wr(timer_pkg::OFF_COMPARE_HIGH[0], 8'h00);
		wr(timer_pkg::OFF_COUNT_LOW, 8'h00);
		idle(100);
		rd(timer_pkg::OFF_STATUS);
		chk("cmp1 suspended", d[6], 1'b0);
		wr(timer_pkg::OFF_COMPARE_LOW[0], 8'h10);
		wr(timer_pkg::OFF_COUNT_LOW, 8'h00);
		idle(100);
		rd(timer_pkg::OFF_STATUS);
		chk("cmp1 resumed", d[6], 1'b1);
		wr(timer_pkg::OFF_COMPARE_LOW[0], 8'h10);
		// Forced level
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h5C);
		idle(2);
		chk("pin one forced", compare_pin_one, 1'b0);
		chk("pin two forced", compare_pin_two, 1'b1);
		rd(timer_pkg::OFF_STATUS);
		chk("force no flag", d[6], 1'b0);
		chk("force no irq", timer_irq, 1'b0);
		// Divide by eight matches one count late
		wr(timer_pkg::OFF_CONTROL_TWO, 8'h82);
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h01);
		wr(timer_pkg::OFF_COUNT_LOW, 8'h00);
		wait_pin(1'b1);
		rd(timer_pkg::OFF_COUNT_LOW);
		chk("div8 match count", d, 8'h11);
		rd(timer_pkg::OFF_STATUS);
		wr(timer_pkg::OFF_COMPARE_LOW[0], 8'h10);
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h08);
		// Capture two: flag, clear, polarity, lock
		wr(timer_pkg::OFF_CONTROL_TWO, 8'h0C);
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h80);
		cap_two_lvl <= 1'b1;
		idle(8);
		rd(timer_pkg::OFF_STATUS);
		chk("cap2 flag", d[4], 1'b1);
		chk("irq capture", timer_irq, 1'b1);
		rd(timer_pkg::OFF_CAPTURE_HIGH[1]);
		rd(timer_pkg::OFF_CAPTURE_LOW[1]);
		rd(timer_pkg::OFF_STATUS);
		chk("cap2 cleared", d[4], 1'b0);
		chk("irq capture off", timer_irq, 1'b0);
		cap_two_lvl <= 1'b0;
		idle(8);
		rd(timer_pkg::OFF_STATUS);
		chk("cap2 wrong edge", d[4], 1'b0);
		rd(timer_pkg::OFF_CAPTURE_HIGH[1]);
		cap_two_lvl <= 1'b1;
		idle(8);
		rd(timer_pkg::OFF_STATUS);
		chk("cap2 locked", d[4], 1'b0);
		rd(timer_pkg::OFF_CAPTURE_LOW[1]);
		cap_two_lvl <= 1'b0;
		idle(8);
		cap_two_lvl <= 1'b1;
		idle(8);
		rd(timer_pkg::OFF_STATUS);
		chk("cap2 unlocked", d[4], 1'b1);
		// One-pulse
		wr(timer_pkg::OFF_CONTROL_ONE, 8'h06);
		wr(timer_pkg::OFF_CONTROL_TWO, 8'hA4);
		cap_one_lvl <= 1'b1;
		wait_pin(1'b1);
		chk("pulse start", compare_pin_one, 1'b1);
		rd(timer_pkg::OFF_STATUS);
		chk("pulse cap1 flag", d[7], 1'b1);
		rd(timer_pkg::OFF_CAPTURE_HIGH[0]);
		chk("pulse cap1 hi", d, 8'hFF);
		rd(timer_pkg::OFF_CAPTURE_LOW[0]);
		chk("pulse cap1 lo", d, 8'hFD);
		wait_pin(1'b0);
		chk("pulse end", compare_pin_one, 1'b0);
		rd(timer_pkg::OFF_STATUS);
		chk("pulse no cmp1 flag", d[6], 1'b0);
		// PWM over one-pulse
		wr(timer_pkg::OFF_CONTROL_TWO, 8'h74);
		chk("pwm oe one", compare_pin_one_oe, 1'b1);
		chk("pwm oe two", compare_pin_two_oe, 1'b0);
		// External clock
		wr(timer_pkg::OFF_CONTROL_TWO, 8'h07);
		wr(timer_pkg::OFF_COUNT_LOW, 8'h00);
		rd(timer_pkg::OFF_COUNT_LOW);
		chk("count reload", d, 8'hFC);
		repeat (3) begin
			ext_req <= 1'b1;
			@(posedge aclk);
			ext_req <= 1'b0;
			idle(10);
		end
		rd(timer_pkg::OFF_COUNT_LOW);
		chk("count ext", d, 8'hFF);
		end_of_test();
	end
endmodule // timer_capture_compare_pulse_bench

`default_nettype wire
